// ### hw/epp_defines.svh
`ifndef EPP_DEFINES_SVH
`define EPP_DEFINES_SVH
// ************************************************************
// register map (byte addresses on the software port)
// ************************************************************
`define EPP_OFS_ADDR_LO 8'h00
`define EPP_OFS_ADDR_HI 8'h04
`define EPP_OFS_TARGET 8'h08
`define EPP_OFS_PASID 8'h0C
`define EPP_OFS_IEC 8'h10
`define EPP_OFS_CMD 8'h14
`define EPP_OFS_STATUS 8'h18
// ************************************************************
// field positions
// ************************************************************
`define EPP_TGT_HINT_LSB 16
`define EPP_TGT_RANGE_BIT 24
`define EPP_TGT_ALL_BIT 25
`define EPP_IEC_MASK_LSB 16
`define EPP_IEC_SCOPE_BIT 24
`define EPP_ST_BUSY_BIT 0
`define EPP_ST_ERR_BIT 1
`define EPP_ST_PEND_LSB 8
`define EPP_ST_REQ_BIT 16
`define EPP_PAGE_SHIFT 12
// ************************************************************
// counts and timing
// ************************************************************
`define EPP_MAX_PEND 32
`define EPP_CLK_MHZ 10
`define EPP_TIMEOUT_US 100
`define EPP_TIMEOUT_CYC (`EPP_TIMEOUT_US * `EPP_CLK_MHZ)
`define EPP_EP_SERVICE_CYC 4
`endif

// ### hw/epp_pkg.sv
`default_nettype none
package epp_pkg;
	typedef enum logic [1:0] {
		EPP_K_TLB = 2'h0,
		EPP_K_EP = 2'h1,
		EPP_K_EP_PASID = 2'h2,
		EPP_K_IEC = 2'h3
	} epp_kind_t;
	typedef enum logic [2:0] {
		EPP_S_IDLE = 3'h0,
		EPP_S_FLUSH = 3'h1,
		EPP_S_DRAIN = 3'h3,
		EPP_S_TLB = 3'h2,
		EPP_S_SEND = 3'h6
	} epp_state_t;
endpackage : epp_pkg
`default_nettype wire

// ### hw/epp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface epp_link_if;
	logic req_valid;
	logic req_ready;
	logic [4:0] req_tag;
	logic [15:0] req_requester;
	logic [63:0] req_addr;
	logic req_range;
	logic req_pasid_en;
	logic req_all_spaces;
	logic [19:0] req_pasid;
	logic rsp_valid;
	logic [4:0] rsp_tag;
	modport dev (output req_valid, req_tag, req_requester, req_addr, req_range, req_pasid_en,
		req_all_spaces, req_pasid, input req_ready, rsp_valid, rsp_tag);
	modport ep (input req_valid, req_tag, req_requester, req_addr, req_range, req_pasid_en,
		req_all_spaces, req_pasid, output req_ready, rsp_valid, rsp_tag);
endinterface : epp_link_if
`default_nettype wire

// ### hw/epp_endpoint.sv
`timescale 1ns/1ps
`default_nettype none
`include "epp_defines.svh"
module epp_endpoint #(
	parameter logic [4:0] HINT = 5'h00,
	parameter int SERVICE_CYC = `EPP_EP_SERVICE_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	epp_link_if.ep link,
	input wire logic rsp_hold,
	output logic purge_valid,
	output logic [15:0] purge_requester,
	output logic [63:0] purge_base,
	output logic [5:0] purge_size_log,
	output logic purge_pasid_en,
	output logic purge_all_spaces,
	output logic [19:0] purge_pasid
);
	import epp_pkg::*;
	localparam int DEPTH = `EPP_MAX_PEND;
	localparam int EW = 5 + 16 + 64 + 1 + 1 + 1 + 20;
	localparam logic [5:0] LIMIT = (HINT == 5'h00) ? 6'(DEPTH) : {1'b0, HINT};
	// ************************************************************
	// decode of the range encoding
	// ************************************************************
	function automatic logic [5:0] size_log(input logic [63:0] a, input logic rng);
		logic [5:0] r;
		r = 6'(`EPP_PAGE_SHIFT);
		if (rng) begin
			r = 6'd63;
			for (int j = 62; j >= `EPP_PAGE_SHIFT; j--) begin
				if (!a[j]) r = 6'(j + 1);
			end
		end
		return r;
	endfunction : size_log

	logic [EW-1:0] mem [DEPTH];
	logic [4:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [15:0] svc_r, svc_nxt;
	logic ready_r, ready_nxt, rsp_r, rsp_nxt;
	logic [4:0] rtag_r, rtag_nxt;
	logic pv_r, pv_nxt;
	logic [EW-1:0] head, pent_r, pent_nxt;
	logic push, pop;

	assign link.req_ready = ready_r;
	assign link.rsp_valid = rsp_r;
	assign link.rsp_tag = rtag_r;
	assign head = mem[rp_r];

	always_comb begin
		push = link.req_valid && ready_r;
		pop = (cnt_r != 6'h00) && (svc_r == 16'h0000) && !rsp_hold;
		wp_nxt = push ? wp_r + 5'h01 : wp_r;
		rp_nxt = pop ? rp_r + 5'h01 : rp_r;
		cnt_nxt = cnt_r + {5'h00, push} - {5'h00, pop};
		// throttle once the hinted number is outstanding
		ready_nxt = (cnt_nxt < LIMIT);
		svc_nxt = svc_r;
		if (pop || cnt_r == 6'h00) begin
			svc_nxt = 16'(SERVICE_CYC - 1);
		end else if (svc_r != 16'h0000) begin
			svc_nxt = svc_r - 16'h0001;
		end
		rsp_nxt = pop;
		rtag_nxt = pop ? head[EW-1 -: 5] : rtag_r;
		pv_nxt = pop;
		pent_nxt = pop ? head : pent_r;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wp_r <= 5'h00;
			rp_r <= 5'h00;
			cnt_r <= 6'h00;
			svc_r <= 16'h0000;
			ready_r <= 1'b0;
			rsp_r <= 1'b0;
			rtag_r <= 5'h00;
			pv_r <= 1'b0;
			pent_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			svc_r <= svc_nxt;
			ready_r <= ready_nxt;
			rsp_r <= rsp_nxt;
			rtag_r <= rtag_nxt;
			pv_r <= pv_nxt;
			pent_r <= pent_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wp_r] <= {link.req_tag, link.req_requester, link.req_addr, link.req_range,
				link.req_pasid_en, link.req_all_spaces, link.req_pasid};
		end
	end

	// ************************************************************
	// purge report, decoded from the registered entry
	// ************************************************************
	logic [63:0] ent_addr;
	logic [5:0] ent_log;
	assign ent_addr = pent_r[EW-22 -: 64];
	assign ent_log = size_log(ent_addr, pent_r[22]);
	assign purge_valid = pv_r;
	assign purge_requester = pent_r[EW-6 -: 16];
	assign purge_size_log = ent_log;
	assign purge_base = ent_addr & ~((64'h1 << ent_log) - 64'h1);
	assign purge_pasid_en = pent_r[21];
	assign purge_all_spaces = pent_r[20];
	assign purge_pasid = pent_r[19:0];
endmodule : epp_endpoint
`default_nettype wire

// ### hw/epp_engine.sv
// Summary of operation
// - request goes only to addressed endpoint
// - plain purge address is second-level, range-qualified
// - range clear: one page, bits 63:12
// - range set: lowest zero bit sets size
// - endpoint takes 32, may throttle past hint
// - hint zero means 32; limits outstanding requests
// - software purges translation cache before plain purge
// - scope one: all spaces; zero: given space
// - space purge address first-level, same encoding
// - software extended purge before space purge
// - scope clear purges all interrupt entries
// - entry index is base of purged range
// - mask n ignores n low bits, 2^n entries
// - drain remapped interrupts during interrupt purge
// - flush write buffers first when required
// - endpoint purge waits for earlier local purges
// - time-out frees tags, flags, stops fetching
`timescale 1ns/1ps
`default_nettype none
`include "epp_defines.svh"
module epp_engine #(
	parameter int TIMEOUT_CYC = `EPP_TIMEOUT_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic write_buffer_flush_required,
	output logic tlb_purge_req,
	input wire logic tlb_purge_done,
	output logic wb_flush_req,
	input wire logic wb_flush_done,
	output logic irq_drain_req,
	input wire logic irq_drain_done,
	output logic iec_purge,
	output logic iec_all,
	output logic [15:0] iec_base,
	output logic [4:0] iec_mask,
	output logic response_timeout_error,
	epp_link_if.dev link
);
	import epp_pkg::*;
	localparam int TAGS = `EPP_MAX_PEND;

	// ************************************************************
	// state
	// ************************************************************
	epp_state_t state_r, state_nxt;
	epp_kind_t kind_r, kind_nxt;
	logic [31:0] alo_r, alo_nxt, ahi_r, ahi_nxt, tgt_r, tgt_nxt, iec_r, iec_nxt;
	logic [19:0] pasid_r, pasid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [TAGS-1:0] busy_r, busy_nxt;
	logic [5:0] pend_r, pend_nxt;
	logic [15:0] tmo_r, tmo_nxt;
	logic err_r, err_nxt;
	logic tlb_r, tlb_nxt, wbf_r, wbf_nxt, drn_r, drn_nxt, iecp_r, iecp_nxt;
	logic iall_r, iall_nxt;
	logic [15:0] ibase_r, ibase_nxt;
	logic [4:0] imask_r, imask_nxt;
	logic rv_r, rv_nxt, rrng_r, rrng_nxt, rpe_r, rpe_nxt, rall_r, rall_nxt;
	logic [4:0] rtag_r, rtag_nxt;
	logic [15:0] rreq_r, rreq_nxt;
	logic [63:0] raddr_r, raddr_nxt;
	logic [19:0] rpas_r, rpas_nxt;

	// ************************************************************
	// combinational next values
	// ************************************************************
	logic [4:0] free_tag;
	logic free_any, launch, idle_wr, issue, retire, expire;
	logic [4:0] hint;
	logic [5:0] limit;
	logic [4:0] mask_n;
	logic [15:0] idx_keep;

	always_comb begin
		free_tag = 5'h00;
		free_any = 1'b0;
		for (int i = TAGS - 1; i >= 0; i--) begin
			if (!busy_r[i]) begin
				free_tag = 5'(i);
				free_any = 1'b1;
			end
		end
		hint = tgt_r[`EPP_TGT_HINT_LSB +: 5];
		limit = (hint == 5'h00) ? 6'(TAGS) : {1'b0, hint};
		mask_n = iec_r[`EPP_IEC_MASK_LSB +: 5];
		idx_keep = 16'hFFFF << mask_n;
		idle_wr = reg_wr && (state_r == EPP_S_IDLE);
		// no new command while the time-out flag stands
		launch = idle_wr && (reg_addr == `EPP_OFS_CMD) && !err_r;
		issue = (state_r == EPP_S_SEND) && !rv_r && free_any && (pend_r < limit);
		retire = link.rsp_valid && busy_r[link.rsp_tag];
		expire = (pend_r != 6'h00) && !link.rsp_valid && (tmo_r == 16'(TIMEOUT_CYC - 1));

		alo_nxt = alo_r;
		ahi_nxt = ahi_r;
		tgt_nxt = tgt_r;
		pasid_nxt = pasid_r;
		iec_nxt = iec_r;
		kind_nxt = kind_r;
		// operands are frozen while a command runs
		if (idle_wr) begin
			unique case (reg_addr)
				`EPP_OFS_ADDR_LO: alo_nxt = reg_wdata;
				`EPP_OFS_ADDR_HI: ahi_nxt = reg_wdata;
				`EPP_OFS_TARGET: tgt_nxt = reg_wdata;
				`EPP_OFS_PASID: pasid_nxt = reg_wdata[19:0];
				`EPP_OFS_IEC: iec_nxt = reg_wdata;
				`EPP_OFS_CMD: kind_nxt = epp_kind_t'(reg_wdata[1:0]);
				default: ;
			endcase
		end

		state_nxt = state_r;
		tlb_nxt = 1'b0;
		wbf_nxt = 1'b0;
		drn_nxt = 1'b0;
		iecp_nxt = 1'b0;
		iall_nxt = iall_r;
		ibase_nxt = ibase_r;
		imask_nxt = imask_r;
		rv_nxt = rv_r;
		rtag_nxt = rtag_r;
		rreq_nxt = rreq_r;
		raddr_nxt = raddr_r;
		rrng_nxt = rrng_r;
		rpe_nxt = rpe_r;
		rall_nxt = rall_r;
		rpas_nxt = rpas_r;
		unique case (state_r)
			EPP_S_IDLE: begin
				if (launch) begin
					unique case (epp_kind_t'(reg_wdata[1:0]))
						EPP_K_TLB: begin
							state_nxt = EPP_S_TLB;
							tlb_nxt = 1'b1;
						end
						EPP_K_EP, EPP_K_EP_PASID: state_nxt = EPP_S_SEND;
						EPP_K_IEC: begin
							if (write_buffer_flush_required) begin
								state_nxt = EPP_S_FLUSH;
								wbf_nxt = 1'b1;
							end else begin
								state_nxt = EPP_S_DRAIN;
								drn_nxt = 1'b1;
							end
						end
					endcase
				end
			end
			EPP_S_TLB: begin
				if (tlb_purge_done) state_nxt = EPP_S_IDLE;
			end
			EPP_S_FLUSH: begin
				if (wb_flush_done) begin
					state_nxt = EPP_S_DRAIN;
					drn_nxt = 1'b1;
				end
			end
			EPP_S_DRAIN: begin
				// cache entries go one cycle after the drain completion
				if (irq_drain_done) begin
					state_nxt = EPP_S_IDLE;
					iecp_nxt = 1'b1;
					iall_nxt = !iec_r[`EPP_IEC_SCOPE_BIT];
					ibase_nxt = iec_r[15:0] & idx_keep;
					imask_nxt = mask_n;
				end
			end
			EPP_S_SEND: begin
				if (issue) begin
					rv_nxt = 1'b1;
					rtag_nxt = free_tag;
					rreq_nxt = tgt_r[15:0];
					// page address only; low bits from 12 up carry the size
					raddr_nxt = {ahi_r, alo_r[31:12], 12'h000};
					rrng_nxt = tgt_r[`EPP_TGT_RANGE_BIT];
					rpe_nxt = (kind_r == EPP_K_EP_PASID);
					rall_nxt = (kind_r == EPP_K_EP_PASID) && tgt_r[`EPP_TGT_ALL_BIT];
					rpas_nxt = (kind_r == EPP_K_EP_PASID) ? pasid_r : 20'h00000;
				end else if (rv_r && link.req_ready) begin
					rv_nxt = 1'b0;
					state_nxt = EPP_S_IDLE;
				end
			end
			default: state_nxt = EPP_S_IDLE;
		endcase

		busy_nxt = busy_r;
		if (retire) busy_nxt[link.rsp_tag] = 1'b0;
		if (issue) busy_nxt[free_tag] = 1'b1;
		pend_nxt = pend_r + {5'h00, issue} - {5'h00, retire};
		// a stuck endpoint is given up as a whole, since the late tag is not known
		if (expire) begin
			busy_nxt = '0;
			pend_nxt = 6'h00;
		end
		tmo_nxt = (pend_r == 6'h00 || link.rsp_valid || expire) ? 16'h0000 : tmo_r + 16'h0001;
		// a new time-out beats a clear in the same cycle
		err_nxt = expire || (err_r && !(reg_wr && reg_addr == `EPP_OFS_STATUS &&
			reg_wdata[`EPP_ST_ERR_BIT]));

		rdata_nxt = 32'h00000000;
		if (reg_rd) begin
			unique case (reg_addr)
				`EPP_OFS_ADDR_LO: rdata_nxt = alo_r;
				`EPP_OFS_ADDR_HI: rdata_nxt = ahi_r;
				`EPP_OFS_TARGET: rdata_nxt = tgt_r;
				`EPP_OFS_PASID: rdata_nxt = {12'h000, pasid_r};
				`EPP_OFS_IEC: rdata_nxt = iec_r;
				`EPP_OFS_CMD: rdata_nxt = {30'h00000000, kind_r};
				`EPP_OFS_STATUS: begin
					rdata_nxt[`EPP_ST_BUSY_BIT] = (state_r != EPP_S_IDLE);
					rdata_nxt[`EPP_ST_ERR_BIT] = err_r;
					rdata_nxt[`EPP_ST_PEND_LSB +: 6] = pend_r;
					rdata_nxt[`EPP_ST_REQ_BIT] = rv_r;
				end
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= EPP_S_IDLE;
			kind_r <= EPP_K_TLB;
			{alo_r, ahi_r, tgt_r, iec_r} <= 128'h0;
			{pasid_r, rdata_r, busy_r} <= 84'h0;
			{pend_r, tmo_r, err_r} <= 23'h0;
			{tlb_r, wbf_r, drn_r, iecp_r} <= 4'h0;
			{iall_r, ibase_r, imask_r} <= 22'h0;
			{rv_r, rtag_r, rreq_r, raddr_r} <= 86'h0;
			{rrng_r, rpe_r, rall_r, rpas_r} <= 23'h0;
		end else begin
			state_r <= state_nxt;
			kind_r <= kind_nxt;
			{alo_r, ahi_r, tgt_r, iec_r} <= {alo_nxt, ahi_nxt, tgt_nxt, iec_nxt};
			{pasid_r, rdata_r, busy_r} <= {pasid_nxt, rdata_nxt, busy_nxt};
			{pend_r, tmo_r, err_r} <= {pend_nxt, tmo_nxt, err_nxt};
			{tlb_r, wbf_r, drn_r, iecp_r} <= {tlb_nxt, wbf_nxt, drn_nxt, iecp_nxt};
			{iall_r, ibase_r, imask_r} <= {iall_nxt, ibase_nxt, imask_nxt};
			{rv_r, rtag_r, rreq_r, raddr_r} <= {rv_nxt, rtag_nxt, rreq_nxt, raddr_nxt};
			{rrng_r, rpe_r, rall_r, rpas_r} <= {rrng_nxt, rpe_nxt, rall_nxt, rpas_nxt};
		end
	end

	assign reg_rdata = rdata_r;
	assign {tlb_purge_req, wb_flush_req} = {tlb_r, wbf_r};
	assign {irq_drain_req, iec_purge} = {drn_r, iecp_r};
	assign {iec_all, iec_base, iec_mask} = {iall_r, ibase_r, imask_r};
	assign response_timeout_error = err_r;
	assign link.req_valid = rv_r;
	assign link.req_tag = rtag_r;
	assign link.req_requester = rreq_r;
	assign link.req_addr = raddr_r;
	assign link.req_range = rrng_r;
	assign link.req_pasid_en = rpe_r;
	assign link.req_all_spaces = rall_r;
	assign link.req_pasid = rpas_r;
endmodule : epp_engine
`default_nettype wire

// ### dv/epp_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module epp_link_checker (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [4:0] req_tag,
	input wire logic [15:0] req_requester,
	input wire logic [63:0] req_addr,
	input wire logic req_range,
	input wire logic req_pasid_en,
	input wire logic req_all_spaces,
	input wire logic [19:0] req_pasid,
	input wire logic rsp_valid,
	input wire logic [4:0] rsp_tag
);
	// ****************
	// tags owed by the far end, as seen on the wire
	// ****************
	logic [31:0] pend_r, pend_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic take;
	always_comb begin
		take = req_valid && req_ready;
		pend_nxt = pend_r;
		if (rsp_valid) pend_nxt[rsp_tag] = 1'b0;
		if (take) pend_nxt[req_tag] = 1'b1;
		cnt_nxt = cnt_r + 6'(take) - 6'(rsp_valid);
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pend_r <= '0;
			cnt_r <= '0;
		end else begin
			pend_r <= pend_nxt;
			cnt_r <= cnt_nxt;
		end
	end
	// ****************
	// properties
	// ****************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_take;
		req_valid && req_ready;
	endsequence
	sequence s_stall;
		req_valid && !req_ready;
	endsequence
	sequence s_quiet;
		!req_valid ##1 !req_valid;
	endsequence
	property p_hold;
		s_stall |=> req_valid;
	endproperty
	property p_stable;
		s_stall |=> $stable(req_addr) && $stable(req_requester) && $stable(req_tag)
			&& $stable({req_range, req_pasid_en, req_all_spaces, req_pasid});
	endproperty
	property p_gap;
		s_take |=> s_quiet;
	endproperty
	property p_page;
		req_valid |-> req_addr[11:0] == 12'h000;
	endproperty
	property p_owed;
		rsp_valid |-> pend_r[rsp_tag];
	endproperty
	property p_tag_free;
		req_valid |-> !pend_r[req_tag];
	endproperty
	property p_limit;
		req_valid |-> cnt_r < 6'h20;
	endproperty
	property p_pulse;
		rsp_valid |=> !rsp_valid;
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped before taken");
	a_stable: assert property (p_stable) else $error("request changed while stalled");
	a_gap: assert property (p_gap) else $error("second request without command");
	a_page: assert property (p_page) else $error("page offset bits not zero");
	a_owed: assert property (p_owed) else $error("response to unknown tag");
	a_tag_free: assert property (p_tag_free) else $error("tag reused while owed");
	a_limit: assert property (p_limit) else $error("more than 32 outstanding");
	a_pulse: assert property (p_pulse) else $error("response longer than a cycle");
endmodule : epp_link_checker
`default_nettype wire

// ### dv/endpoint_and_irq_cache_purge_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "epp_defines.svh"
module endpoint_and_irq_cache_purge_tb;
	localparam int TMO = 40;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic write_buffer_flush_required = 1'b0;
	logic rsp_hold = 1'b0;
	logic [31:0] reg_rdata, rv;
	logic tlb_purge_req, wb_flush_req, irq_drain_req, iec_purge, iec_all, response_timeout_error;
	logic [15:0] iec_base, purge_requester, cap_base;
	logic [4:0] iec_mask, cap_mask;
	logic purge_valid, purge_pasid_en, purge_all_spaces, cap_all;
	logic [63:0] purge_base, a;
	logic [5:0] purge_size_log;
	logic [19:0] purge_pasid;
	logic [3:0] tq = 4'h0, fq = 4'h0, dq = 4'h0;
	logic [11:0] trace = 12'h000;
	logic [7:0] ep_n = 8'h00, n0;
	int bad_count = 0, samples_checked = 0, cyc = 0;
	// completion partners answer four cycles late so refusals can be seen
	wire tlb_purge_done = tq[3];
	wire wb_flush_done = fq[3];
	wire irq_drain_done = dq[3];
	epp_link_if epp_link_if_i ();
	epp_engine #(.TIMEOUT_CYC(TMO)) epp_engine_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .write_buffer_flush_required(write_buffer_flush_required),
		.tlb_purge_req(tlb_purge_req), .tlb_purge_done(tlb_purge_done),
		.wb_flush_req(wb_flush_req), .wb_flush_done(wb_flush_done),
		.irq_drain_req(irq_drain_req), .irq_drain_done(irq_drain_done), .iec_purge(iec_purge),
		.iec_all(iec_all), .iec_base(iec_base), .iec_mask(iec_mask),
		.response_timeout_error(response_timeout_error), .link(epp_link_if_i));
	// endpoint throttles past two so the link stall path is exercised
	epp_endpoint #(.HINT(5'h02), .SERVICE_CYC(4)) epp_endpoint_i (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .link(epp_link_if_i), .rsp_hold(rsp_hold), .purge_valid(purge_valid),
		.purge_requester(purge_requester), .purge_base(purge_base),
		.purge_size_log(purge_size_log), .purge_pasid_en(purge_pasid_en),
		.purge_all_spaces(purge_all_spaces), .purge_pasid(purge_pasid));
	epp_link_checker epp_link_checker_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.req_valid(epp_link_if_i.req_valid), .req_ready(epp_link_if_i.req_ready),
		.req_tag(epp_link_if_i.req_tag), .req_requester(epp_link_if_i.req_requester),
		.req_addr(epp_link_if_i.req_addr), .req_range(epp_link_if_i.req_range),
		.req_pasid_en(epp_link_if_i.req_pasid_en), .req_all_spaces(epp_link_if_i.req_all_spaces),
		.req_pasid(epp_link_if_i.req_pasid), .rsp_valid(epp_link_if_i.rsp_valid),
		.rsp_tag(epp_link_if_i.rsp_tag));
	// ****************
	// clock, partners, monitors
	// ****************
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		tq <= {tq[2:0], tlb_purge_req};
		fq <= {fq[2:0], wb_flush_req};
		dq <= {dq[2:0], irq_drain_req};
		if (tlb_purge_req) trace <= {trace[8:0], 3'h4};
		else if (wb_flush_req) trace <= {trace[8:0], 3'h1};
		else if (irq_drain_req) trace <= {trace[8:0], 3'h2};
		else if (iec_purge) trace <= {trace[8:0], 3'h3};
		if (iec_purge) {cap_all, cap_base, cap_mask} <= {iec_all, iec_base, iec_mask};
		if (purge_valid) ep_n <= ep_n + 8'h01;
		cyc = cyc + 1;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			stop_test();
		end
	end
	// ****************
	// tasks
	// ****************
	task automatic stop_test();
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask : wr
	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		@(posedge sys_clk);
	endtask : rd
	task automatic idle();
		for (int i = 0; i < 100; i++) begin
			rd(`EPP_OFS_STATUS, rv);
			if (rv[0] === 1'b0) break;
		end
	endtask : idle
	task automatic wait_ep(input logic [7:0] n);
		for (int i = 0; i < 60; i++) begin
			if (ep_n === n) break;
			@(posedge sys_clk);
		end
	endtask : wait_ep
	task automatic ep(input logic [1:0] k, input logic [63:0] ad, input logic [31:0] t);
		logic [7:0] n;
		n = ep_n + 8'h01;
		wr(`EPP_OFS_ADDR_LO, ad[31:0]);
		wr(`EPP_OFS_ADDR_HI, ad[63:32]);
		wr(`EPP_OFS_TARGET, t);
		wr(`EPP_OFS_CMD, {30'h0, k});
		idle();
		wait_ep(n);
	endtask : ep
	task automatic iec(input logic s, input logic [15:0] x, input logic [4:0] m,
		input logic cap, input logic [15:0] eb, input logic [8:0] etr);
		write_buffer_flush_required <= cap;
		wr(`EPP_OFS_IEC, {7'h00, s, 3'h0, m, x});
		wr(`EPP_OFS_CMD, 32'h00000003);
		idle();
		chk(trace[8:0], etr);
		chk(cap_all, !s);
		if (s) chk({cap_base, cap_mask}, {eb, m});
	endtask : iec
	// ****************
	// main sequence
	// ****************
	initial begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(`EPP_OFS_STATUS, rv);
		chk(rv, 0);
		rd(8'hFC, rv);
		chk(rv, 0);
		wr(`EPP_OFS_CMD, 32'h00000000);
		idle();
		ep(2'h1, 64'h000000A5_12345ABC, 32'h00001234);
		chk(purge_requester, 16'h1234);
		chk(purge_base, 64'h000000A5_12345000);
		chk({purge_size_log, purge_pasid_en}, {6'd12, 1'b0});
		for (int k = 0; k < 4; k++) begin
			a = {32'h00000077, 32'hABC00000 | (((32'h1 << k) - 1) << 12)};
			ep(2'h1, a, 32'h01000042);
			chk(purge_base, a & ~((64'h1 << (13 + k)) - 1));
			chk(purge_size_log, 6'(13 + k));
		end
		for (int g = 0; g < 2; g++) begin
			wr(`EPP_OFS_PASID, 32'h0005A5A5);
			wr(`EPP_OFS_CMD, 32'h00000000);
			idle();
			ep(2'h2, 64'h00000001_00003000, {6'h00, g[0], 9'h000, 16'hBEEF});
			chk({purge_pasid_en, purge_all_spaces}, {1'b1, g[0]});
			chk({purge_requester, purge_base}, {16'hBEEF, 64'h00000001_00003000});
			if (g == 0) chk(purge_pasid, 20'h5A5A5);
		end
		n0 = ep_n;
		wr(`EPP_OFS_CMD, 32'h00000000);
		wr(`EPP_OFS_CMD, 32'h00000001);
		idle();
		repeat (10) @(posedge sys_clk);
		chk({trace[2:0], ep_n}, {3'h4, n0});
		iec(1'b1, 16'h1237, 5'd2, 1'b1, 16'h1234, 9'h053);
		iec(1'b1, 16'h00FF, 5'd4, 1'b0, 16'h00F0, 9'h0D3);
		iec(1'b0, 16'h0000, 5'd0, 1'b0, 16'h0000, 9'h0D3);
		for (int h = 0; h < 2; h++) begin
			n0 = ep_n;
			rsp_hold <= 1'b1;
			wr(`EPP_OFS_TARGET, (h != 0) ? 32'h00000055 : 32'h00020055);
			for (int i = 0; i < 3; i++) begin
				wr(`EPP_OFS_CMD, 32'h00000001);
				if (i < 2) idle();
			end
			repeat (4) @(posedge sys_clk);
			rd(`EPP_OFS_STATUS, rv);
			// hint 2: third held in the engine; hint 0: third stalled by the endpoint
			chk(rv[16:0], (h != 0) ? 17'h10301 : 17'h00201);
			rsp_hold <= 1'b0;
			idle();
			wait_ep(n0 + 8'h03);
			chk(ep_n, n0 + 8'h03);
		end
		rsp_hold <= 1'b1;
		wr(`EPP_OFS_CMD, 32'h00000001);
		idle();
		repeat (TMO + 10) @(posedge sys_clk);
		rd(`EPP_OFS_STATUS, rv);
		chk({response_timeout_error, rv[13:8], rv[1]}, {1'b1, 6'h00, 1'b1});
		rsp_hold <= 1'b0;
		repeat (20) @(posedge sys_clk);
		n0 = ep_n;
		wr(`EPP_OFS_CMD, 32'h00000001);
		repeat (20) @(posedge sys_clk);
		chk(ep_n, n0);
		wr(`EPP_OFS_STATUS, 32'h00000002);
		wr(`EPP_OFS_CMD, 32'h00000001);
		idle();
		wait_ep(n0 + 8'h01);
		chk({response_timeout_error, ep_n}, {1'b0, n0 + 8'h01});
		stop_test();
	end
endmodule : endpoint_and_irq_cache_purge_tb
`default_nettype wire
